// ==== pkg/llpcs_pkg.sv ====
package llpcs_pkg;

   // ************************************************************
   // Widths and modes
   // ************************************************************
   localparam int unsigned PCS_W_MAX  = 20;
   localparam int unsigned FAB_W_MAX  = 2 * PCS_W_MAX;
   localparam int unsigned WA_LEN_20  = 20;
   localparam int unsigned SYNC_DEPTH = 3;

   typedef enum logic [1:0] {
      LLPCS_W8  = 2'h0,
      LLPCS_W10 = 2'h1,
      LLPCS_W16 = 2'h2,
      LLPCS_W20 = 2'h3
   } llpcs_width_type;

   typedef enum logic [1:0] {
      LLPCS_BYPASSED = 2'h0,
      LLPCS_DISABLED = 2'h1,
      LLPCS_ENABLED  = 2'h2
   } llpcs_mode_type;

   typedef struct packed {
      llpcs_width_type width;
      llpcs_mode_type  ser_mode;
      llpcs_mode_type  des_mode;
      logic            tx_reg_mode;
      logic [4:0]      wa_len;
      logic            byte_order_req;
   } llpcs_cfg_type;

   typedef struct packed {
      logic [FAB_W_MAX-1:0] data;
   } llpcs_word_type;

   // Byte serializer phase states
   typedef enum logic [1:0] {
      LLPCS_PH_LOW  = 2'b00,
      LLPCS_PH_HIGH = 2'b01
   } llpcs_phase_type;

endpackage : llpcs_pkg

// ==== logic/llpcs_buf2.sv ====
`timescale 1ns/100ps
module llpcs_buf2 #(
   parameter int unsigned W     = 40,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         clr,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_q [DEPTH];
   logic [W-1:0]  mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   // ************************************************************
   // Pointers and count
   // ************************************************************
   always_comb begin
      push  = in_valid && in_ready;
      pop   = out_valid && out_ready;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      mem_d = mem_q;
      if (clr) begin
         wr_d  = '0;
         rd_d  = '0;
         cnt_d = '0;
      end else begin
         if (push) begin
            mem_d[wr_q] = in_data;
            wr_d        = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (ce) begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
endmodule : llpcs_buf2

// ==== logic/llpcs_datapath.sv ====
// Functional notes
// - PCS widths 8, 10, 16, 20 supported.
// - Only phase FIFOs and byte (de)serializers present.
// - Both phase compensation FIFOs always in path.
// - Byte serializer/deserializer each selectable per rate.
// - Disabled function passes data, keeps its delay.
// - Bypassed function removed, adds no delay.
// - Byte ordering only with 20-bit alignment pattern.
// - TX phase FIFO may be single register stage.
`timescale 1ns/100ps
module llpcs_datapath
   import llpcs_pkg::*;
#(
   parameter int unsigned PW = llpcs_pkg::PCS_W_MAX
) (
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   input  wire logic                          ce,
   input  wire llpcs_pkg::llpcs_cfg_type      cfg,
   input  wire llpcs_pkg::llpcs_word_type     tx_fab_data,
   input  wire logic                          tx_fab_valid,
   output logic                               tx_fab_ready,
   output logic [PW-1:0]                      tx_pma_data,
   output logic                               tx_pma_valid,
   input  wire logic [PW-1:0]                 rx_pma_data,
   input  wire logic                          rx_pma_valid,
   output llpcs_pkg::llpcs_word_type          rx_fab_data,
   output logic                               rx_fab_valid,
   input  wire logic                          rx_fab_ready,
   output logic                               byte_order_avail,
   output logic                               rx_overflow
);
   import llpcs_pkg::*;

   localparam int unsigned FW = 2 * PW;

   // ************************************************************
   // Reset release
   // ************************************************************
   logic rst_s1_q, rst_n_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ************************************************************
   // Configuration decode
   // ************************************************************
   logic [PW-1:0] pcs_mask;
   logic [4:0]    pcs_sh;
   logic          ser_on, ser_dly, des_on, des_dly;
   always_comb begin
      unique case (cfg.width)
         LLPCS_W8:  pcs_sh = 5'h08;
         LLPCS_W10: pcs_sh = 5'h0a;
         LLPCS_W16: pcs_sh = 5'h10;
         LLPCS_W20: pcs_sh = 5'h14;
      endcase
      pcs_mask = PW'((FW'(1) << pcs_sh) - FW'(1));
      ser_on  = (cfg.ser_mode == LLPCS_ENABLED);
      ser_dly = (cfg.ser_mode != LLPCS_BYPASSED);
      des_on  = (cfg.des_mode == LLPCS_ENABLED);
      des_dly = (cfg.des_mode != LLPCS_BYPASSED);
   end

   // ************************************************************
   // TX phase compensation FIFO (never removable)
   // ************************************************************
   logic [FW-1:0] txf_data;
   logic          txf_valid, txf_ready;
   logic          tx_reg_sel;
   logic          tx_rdy_q, tx_rdy_d;
   assign tx_reg_sel = cfg.tx_reg_mode;

   // Register mode keeps a single stage; FIFO mode gives full two-entry slack
   logic [FW-1:0] txr_q, txr_d;
   logic          txr_v_q, txr_v_d;
   logic [FW-1:0] txb_data;
   logic          txb_valid, txb_in_ready;

   llpcs_buf2 #(.W(FW), .DEPTH(2)) u_tx_fifo (
      .clk      (clk),
      .rst_n    (rst_n_q),
      .ce       (ce),
      .clr      (tx_reg_sel),
      .in_data  (tx_fab_data.data[FW-1:0]),
      .in_valid (tx_fab_valid && tx_rdy_q && !tx_reg_sel),
      .in_ready (txb_in_ready),
      .out_data (txb_data),
      .out_valid(txb_valid),
      .out_ready(txf_ready && !tx_reg_sel)
   );

   always_comb begin
      txr_d   = txr_q;
      txr_v_d = txr_v_q;
      if (!tx_reg_sel) begin
         txr_v_d = 1'b0;
      end else if (txf_ready || !txr_v_q) begin
         txr_d   = tx_fab_data.data[FW-1:0];
         txr_v_d = tx_fab_valid && tx_rdy_q;
      end
   end

   assign txf_data     = tx_reg_sel ? txr_q : txb_data;
   assign txf_valid    = tx_reg_sel ? txr_v_q : txb_valid;

   // ************************************************************
   // TX byte serializer
   // ************************************************************
   llpcs_phase_type tph_q, tph_d;
   logic [PW-1:0]   tdat_q, tdat_d;
   logic            tval_q, tval_d;
   always_comb begin
      tph_d     = tph_q;
      tdat_d    = tdat_q;
      tval_d    = 1'b0;
      txf_ready = 1'b0;
      if (ser_on) begin
         // One fabric word every two PMA cycles, low half first
         unique case (tph_q)
            LLPCS_PH_LOW: begin
               if (txf_valid) begin
                  tdat_d = txf_data[PW-1:0] & pcs_mask;
                  tval_d = 1'b1;
                  tph_d  = LLPCS_PH_HIGH;
               end
            end
            LLPCS_PH_HIGH: begin
               tdat_d    = PW'(txf_data >> pcs_sh) & pcs_mask;
               tval_d    = 1'b1;
               txf_ready = 1'b1;
               tph_d     = LLPCS_PH_LOW;
            end
            default: tph_d = LLPCS_PH_LOW;
         endcase
      end else begin
         tph_d     = LLPCS_PH_LOW;
         txf_ready = 1'b1;
         tdat_d    = txf_data[PW-1:0] & pcs_mask;
         tval_d    = txf_valid;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tph_q   <= LLPCS_PH_LOW;
         tdat_q  <= '0;
         tval_q  <= 1'b0;
         txr_q   <= '0;
         txr_v_q <= 1'b0;
      end else if (ce) begin
         tph_q   <= tph_d;
         tdat_q  <= tdat_d;
         tval_q  <= tval_d;
         txr_q   <= txr_d;
         txr_v_q <= txr_v_d;
      end
   end

   // Bypassed serializer: output straight from FIFO head, no added stage
   logic [PW-1:0] tx_out_d;
   logic          tx_out_v_d;
   logic [PW-1:0] tx_out_q;
   logic          tx_out_v_q;
   always_comb begin
      // Ready comes from next-cycle room, so the registered copy never overstates it
      tx_rdy_d = tx_reg_sel ? (!ser_on || (tph_d == LLPCS_PH_HIGH) || !txr_v_d)
                            : ((txb_valid && txf_ready) ||
                               (txb_in_ready && !(txb_valid && tx_fab_valid && tx_rdy_q)));
      if (ser_dly) begin
         tx_out_d   = tdat_q;
         tx_out_v_d = tval_q;
      end else begin
         tx_out_d   = tdat_d;
         tx_out_v_d = tval_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_out_q   <= '0;
         tx_out_v_q <= 1'b0;
         tx_rdy_q   <= 1'b0;
      end else if (ce) begin
         tx_out_q   <= tx_out_d;
         tx_out_v_q <= tx_out_v_d;
         tx_rdy_q   <= tx_rdy_d;
      end
   end
   assign tx_pma_data  = tx_out_q;
   assign tx_pma_valid = tx_out_v_q;
   assign tx_fab_ready = tx_rdy_q;

   // ************************************************************
   // RX byte deserializer
   // ************************************************************
   llpcs_phase_type rph_q, rph_d;
   logic [PW-1:0]   rlow_q, rlow_d;
   logic [FW-1:0]   rw_q, rw_d;
   logic            rwv_q, rwv_d;
   logic [FW-1:0]   rin_data;
   logic            rin_valid, rin_ready;
   always_comb begin
      rph_d  = rph_q;
      rlow_d = rlow_q;
      rw_d   = rw_q;
      rwv_d  = 1'b0;
      if (rx_pma_valid) begin
         if (des_on) begin
            unique case (rph_q)
               LLPCS_PH_LOW: begin
                  rlow_d = rx_pma_data & pcs_mask;
                  rph_d  = LLPCS_PH_HIGH;
               end
               LLPCS_PH_HIGH: begin
                  rw_d  = (FW'(rx_pma_data & pcs_mask) << pcs_sh) | FW'(rlow_q);
                  rwv_d = 1'b1;
                  rph_d = LLPCS_PH_LOW;
               end
               default: rph_d = LLPCS_PH_LOW;
            endcase
         end else begin
            rw_d  = {{PW{1'b0}}, rx_pma_data & pcs_mask};
            rwv_d = 1'b1;
            rph_d = LLPCS_PH_LOW;
         end
      end
      // Bypassed: skip the deserializer register entirely
      rin_data  = des_dly ? rw_q : rw_d;
      rin_valid = des_dly ? rwv_q : rwv_d;
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rph_q  <= LLPCS_PH_LOW;
         rlow_q <= '0;
         rw_q   <= '0;
         rwv_q  <= 1'b0;
      end else if (ce) begin
         rph_q  <= rph_d;
         rlow_q <= rlow_d;
         rw_q   <= rw_d;
         rwv_q  <= rwv_d;
      end
   end

   // ************************************************************
   // RX phase compensation FIFO
   // ************************************************************
   // PMA side cannot stall; a full FIFO means the fabric side held rx_fab_ready low
   logic [FW-1:0] rxb_data;
   logic          rxb_valid;
   logic          ov_q, ov_d, boa_q, boa_d;
   llpcs_buf2 #(.W(FW), .DEPTH(2)) u_rx_fifo (
      .clk      (clk),
      .rst_n    (rst_n_q),
      .ce       (ce),
      .clr      (1'b0),
      .in_data  (rin_data),
      .in_valid (rin_valid),
      .in_ready (rin_ready),
      .out_data (rxb_data),
      .out_valid(rxb_valid),
      .out_ready(rx_fab_ready)
   );

   always_comb begin
      ov_d  = ov_q || (rin_valid && !rin_ready);
      boa_d = (cfg.wa_len == 5'(WA_LEN_20)) && cfg.byte_order_req;
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ov_q  <= 1'b0;
         boa_q <= 1'b0;
      end else if (ce) begin
         ov_q  <= ov_d;
         boa_q <= boa_d;
      end
   end

   assign rx_fab_data.data = FAB_W_MAX'(rxb_data);
   assign rx_fab_valid     = rxb_valid;
   assign rx_overflow      = ov_q;
   assign byte_order_avail = boa_q;
endmodule : llpcs_datapath

// ==== testbench/llpcs_datapath_sva.sv ====
`timescale 1ns/100ps
module llpcs_chk
   import llpcs_pkg::*;
#(
   parameter int unsigned PW = 20
) (
   input wire logic                      clk,
   input wire logic                      arst_n,
   input wire logic                      ce,
   input wire llpcs_pkg::llpcs_cfg_type  cfg,
   input wire logic                      tx_fab_valid,
   input wire logic [PW-1:0]             tx_pma_data,
   input wire logic                      tx_pma_valid,
   input wire logic                      rx_pma_valid,
   input wire llpcs_pkg::llpcs_word_type rx_fab_data,
   input wire logic                      rx_fab_valid,
   input wire logic                      rx_fab_ready,
   input wire logic                      byte_order_avail,
   input wire logic                      rx_overflow
);
   logic [PW-1:0] msk;
   logic [2:0]    up_d;
   logic [2:0]    up_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   always_comb begin
      case (cfg.width)
         LLPCS_W8:  msk = PW'(20'h000ff);
         LLPCS_W10: msk = PW'(20'h003ff);
         LLPCS_W16: msk = PW'(20'h0ffff);
         default:   msk = PW'(20'hfffff);
      endcase
      up_d = (up_q == 3'h7) ? up_q : up_q + 3'h1;
   end

   // Config flags are only trusted once the synchronised reset has settled
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         up_q <= 3'h0;
      end else begin
         up_q <= up_d;
      end
   end

   property p_mask;
      tx_pma_valid |-> (tx_pma_data & ~msk) == '0;
   endproperty
   a_mask: assert property (p_mask)
      else $error("pma data beyond width");
   property p_bo;
      up_q == 3'h7 && $stable(cfg) |->
         byte_order_avail == (cfg.wa_len == 5'h14 && cfg.byte_order_req);
   endproperty
   a_bo: assert property (p_bo)
      else $error("byte order flag wrong");
   property p_sticky;
      rx_overflow |=> rx_overflow;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("overflow flag cleared");
   property p_hold;
      rx_fab_valid && !rx_fab_ready |=> rx_fab_valid && $stable(rx_fab_data);
   endproperty
   a_hold: assert property (p_hold)
      else $error("rx head lost while stalled");
   property p_txdrain;
      (ce && !tx_fab_valid)[*8] ##1 (ce && !tx_fab_valid)[*8] |-> !tx_pma_valid;
   endproperty
   a_txdrain: assert property (p_txdrain)
      else $error("tx output without input");
   property p_rxdrain;
      (ce && !rx_pma_valid && rx_fab_ready)[*8] ##1
         (ce && !rx_pma_valid && rx_fab_ready)[*8] |-> !rx_fab_valid;
   endproperty
   a_rxdrain: assert property (p_rxdrain)
      else $error("rx output without input");
   property p_quiet;
      $rose(arst_n) |-> (!tx_pma_valid && !rx_fab_valid && !rx_overflow)[*2];
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("outputs active after reset");
   property p_ovf;
      $rose(rx_overflow) |-> rx_fab_valid &&
         ($past(rx_pma_valid) || $past(rx_pma_valid, 2) || $past(rx_pma_valid, 3));
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow without arrival");
endmodule : llpcs_chk

// ==== testbench/llpcs_pma_model.sv ====
`timescale 1ns/100ps
module llpcs_pma_model #(
   parameter int unsigned PW = 20
) (
   input  wire logic          clk,
   input  wire logic [PW-1:0] tx_pma_data,
   input  wire logic          tx_pma_valid,
   output logic [PW-1:0]      rx_pma_data,
   output logic               rx_pma_valid
);
   initial begin
      rx_pma_data  = '0;
      rx_pma_valid = 1'b0;
   end
   // Loopback on the same clock: phase FIFOs cannot absorb a rate offset
   always @(posedge clk) begin
      rx_pma_valid <= tx_pma_valid;
      rx_pma_data  <= tx_pma_valid ? tx_pma_data : ~rx_pma_data;
   end
endmodule : llpcs_pma_model

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   import llpcs_pkg::*;
   localparam int unsigned PW = 20;
   logic           clk = 1'b0, arst_n = 1'b0, ce = 1'b1;
   logic           tx_fab_valid = 1'b0, rx_fab_ready = 1'b1;
   llpcs_cfg_type  cfg = '0;
   llpcs_word_type tx_fab_data = '0, rx_fab_data;
   logic           tx_fab_ready, tx_pma_valid, rx_pma_valid, rx_fab_valid;
   logic           byte_order_avail, rx_overflow;
   logic [PW-1:0]  tx_pma_data, rx_pma_data;
   int             failures = 0, samples_checked = 0, seed = 32'h260a;
   int             lat [3];

   always #2 clk = ~clk;

   llpcs_datapath #(.PW(PW)) u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .cfg(cfg),
      .tx_fab_data(tx_fab_data), .tx_fab_valid(tx_fab_valid), .tx_fab_ready(tx_fab_ready),
      .tx_pma_data(tx_pma_data), .tx_pma_valid(tx_pma_valid), .rx_pma_data(rx_pma_data),
      .rx_pma_valid(rx_pma_valid), .rx_fab_data(rx_fab_data), .rx_fab_valid(rx_fab_valid),
      .rx_fab_ready(rx_fab_ready), .byte_order_avail(byte_order_avail),
      .rx_overflow(rx_overflow));
   llpcs_pma_model #(.PW(PW)) u_pma (.clk(clk), .tx_pma_data(tx_pma_data),
      .tx_pma_valid(tx_pma_valid), .rx_pma_data(rx_pma_data), .rx_pma_valid(rx_pma_valid));

   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick

   task automatic check(string name, logic [39:0] exp, logic [39:0] got);
      samples_checked++;
      if (exp !== got) begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic give_verdict;
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   function automatic int pcs_n(llpcs_width_type w);
      case (w)
         LLPCS_W8:  return 8;
         LLPCS_W10: return 10;
         LLPCS_W16: return 16;
         default:   return 20;
      endcase
   endfunction : pcs_n

   task automatic do_reset(llpcs_cfg_type c);
      arst_n = 1'b0;
      cfg = c;
      repeat (5) tick();
      arst_n = 1'b1;
      repeat (20) tick();
   endtask : do_reset

   // One word at a time, so the measured latency belongs to that word
   task automatic send(input logic [39:0] w, input bit rx_on, output int lat_o);
      int          n;
      int          t;
      logic [39:0] m;
      n = pcs_n(cfg.width);
      m = (40'h1 << n) - 40'h1;
      tx_fab_data.data = w;
      tx_fab_valid = 1'b1;
      t = 0;
      while (tx_fab_ready !== 1'b1 && t < 50) begin
         tick();
         t++;
      end
      check("tx_fab_ready", 40'h1, 40'(tx_fab_ready));
      tick();
      tx_fab_valid = 1'b0;
      t = 0;
      while (tx_pma_valid !== 1'b1 && t < 20) begin
         tick();
         t++;
      end
      lat_o = t;
      check("tx_pma_valid", 40'h1, 40'(tx_pma_valid));
      check("tx_pma_lo", w & m, 40'(tx_pma_data));
      if (cfg.ser_mode == LLPCS_ENABLED) begin
         tick();
         check("tx_pma_hi", (w >> n) & m, 40'(tx_pma_data));
         m = (m << n) | m;
      end
      t = 0;
      while (rx_on && rx_fab_valid !== 1'b1 && t < 20) begin
         tick();
         t++;
      end
      if (rx_on) begin
         check("rx_fab_valid", 40'h1, 40'(rx_fab_valid));
         check("rx_fab", w & m, rx_fab_data.data);
         tick();
      end
   endtask : send

   // Words back to back with valid held; each must come back once and in order
   task automatic burst(input int nw);
      logic [39:0] q [8];
      logic [39:0] m;
      int          i;
      int          j;
      int          t;
      bit          acc;
      m = (40'h1 << (2 * pcs_n(cfg.width))) - 40'h1;
      for (int k = 0; k < 8; k++) begin
         q[k] = 40'({$random(seed), $random(seed)});
      end
      i = 0;
      j = 0;
      t = 0;
      tx_fab_data.data = q[0];
      tx_fab_valid = 1'b1;
      while (j < nw && t < 200) begin
         acc = tx_fab_valid && (tx_fab_ready === 1'b1);
         if (rx_fab_valid === 1'b1) begin
            check("rx_burst", q[j] & m, rx_fab_data.data);
            j++;
         end
         tick();
         t++;
         if (acc) begin
            i++;
            tx_fab_valid = (i < nw);
            tx_fab_data.data = q[i % 8];
         end
      end
      check("burst_sent", 40'(nw), 40'(i));
      check("burst_back", 40'(nw), 40'(j));
   endtask : burst

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      llpcs_cfg_type c;
      logic [39:0]   w0;
      int            l;
      for (int wi = 0; wi < 4; wi++) begin
         for (int mi = 0; mi < 3; mi++) begin
            c = '0;
            c.width = llpcs_width_type'(wi);
            c.ser_mode = llpcs_mode_type'(mi);
            c.des_mode = llpcs_mode_type'(mi);
            c.tx_reg_mode = wi[1];
            c.wa_len = wi[0] ? 5'h14 : 5'($random(seed));
            c.byte_order_req = 1'($random(seed));
            do_reset(c);
            check("byte_order", 40'(c.wa_len == 5'h14 && c.byte_order_req),
                  40'(byte_order_avail));
            repeat (3) send(40'({$random(seed), $random(seed)}), 1'b1, l);
            lat[mi] = l;
         end
         check("lat_disabled", 40'(lat[0] + 1), 40'(lat[1]));
         check("lat_enabled", 40'(lat[1]), 40'(lat[2]));
         burst(6);
      end
      c = '0;
      do_reset(c);
      rx_fab_ready = 1'b0;
      w0 = 40'({$random(seed), $random(seed)});
      send(w0, 1'b0, l);
      repeat (5) send(40'({$random(seed), $random(seed)}), 1'b0, l);
      repeat (4) tick();
      check("rx_overflow", 40'h1, 40'(rx_overflow));
      check("rx_head", w0 & 40'hff, rx_fab_data.data);
      rx_fab_ready = 1'b1;
      repeat (4) tick();
      check("rx_overflow", 40'h1, 40'(rx_overflow));
      do_reset(c);
      check("rx_overflow", 40'h0, 40'(rx_overflow));
      give_verdict();
   end

   initial begin
      #100000;
      failures++;
      give_verdict();
   end
endmodule : tb_top

bind llpcs_datapath llpcs_chk #(.PW(PW)) u_chk (.clk(clk), .arst_n(arst_n), .ce(ce),
   .cfg(cfg), .tx_fab_valid(tx_fab_valid), .tx_pma_data(tx_pma_data),
   .tx_pma_valid(tx_pma_valid), .rx_pma_valid(rx_pma_valid), .rx_fab_data(rx_fab_data),
   .rx_fab_valid(rx_fab_valid), .rx_fab_ready(rx_fab_ready),
   .byte_order_avail(byte_order_avail), .rx_overflow(rx_overflow));
